// file: twm_master.sv
/*
  twm_master: two-wire bus master with AXI4-Lite registers and one interrupt.
  Assumes open-drain pads with pull-ups outside; pins are asynchronous to mclk.
*/
// Decided for this implementation: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
// Behaviour
// R1 - software keeps each divider times two to the exponent at or below 16383
// R2 - master disable freezes the transfer; complete and ready flags keep values
// R3 - software waits for transfer end and masks interrupts before disabling
// R4 - complete and not-acknowledge rise together; status read clears not-acknowledge
// R5 - software reads status only after completion, else not-acknowledge is lost
// R6 - receive holding register loads every data byte, even transmitted ones, silently
// R7 - software reads received bytes before transmitting new data
// R8 - software reset mid-frame with clock low blocks every later transfer
// R9 - stop omitted when same address restarts right after completion
// R10 - software waits one serial clock period before reusing the address
// R11 - frames carry start, address, data with acknowledges, and stop
module twm_master
   import twm_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        rstn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        scl_in,
   output logic             scl_out,
   output logic             scl_oe,
   input  wire logic        sda_in,
   output logic             sda_out,
   output logic             sda_oe,
   output logic             irq
);
   logic [1:0]    rst_pipe;
   logic          rst_n;
   logic [1:0]    pins_s;
   logic          scl_s;
   logic          sda_s;
   twm_state_type state;
   twm_div_type   div;
   twm_mode_type  mode;
   logic [6:0]    last_addr;
   logic [14:0]   cnt;
   logic [14:0]   low_t;
   logic [14:0]   high_t;
   logic [7:0]    shifter;
   logic [3:0]    bit_cnt;
   logic          is_addr;
   logic          rd_data;
   logic          master_en;
   logic          stuck;
   logic          stop_req;
   logic          transfer_complete_flag;
   logic          transmit_ready_flag;
   logic          receive_ready_flag;
   logic          nack_flag;
   logic          nack_pend;
   logic [7:0]    thr;
   logic [7:0]    rhr;
   logic [2:0]    irq_stat;
   logic [2:0]    irq_mask;
   logic          evt_done;
   logic          evt_byte;
   logic          evt_rxbyte;
   logic          evt_take;
   logic          evt_nack;
   logic          wr_go;
   logic          rd_go;
   logic [7:0]    wr_cmd;
   logic          wr_swrst;
   logic          start_go;
   logic          rd_status;
   logic          wr_ok;
   logic          rd_ok;
   logic [31:0]   rd_val;

   // reset release through two flops
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         rst_pipe <= 2'h0;
      else
         rst_pipe <= {rst_pipe[0], 1'b1};
   end
   assign rst_n = rst_pipe[1];

   twm_sync #(.WIDTH(2)) u_sync (
      .clk   (mclk),
      .rst_n (rst_n),
      .din   ({scl_in, sda_in}),
      .dout  (pins_s)
   );
   assign scl_s   = pins_s[1];
   assign sda_s   = pins_s[0];
   assign scl_out = 1'b0;
   assign sda_out = 1'b0;

   // bus handshake: write address and data are taken together
   assign wr_go         = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
   assign s_axi_awready = wr_go;
   assign s_axi_wready  = wr_go;
   assign rd_go         = s_axi_arvalid && !s_axi_rvalid;
   assign s_axi_arready = rd_go;
   assign wr_ok = (s_axi_awaddr <= TWM_THR_OFS) && (s_axi_awaddr[1:0] == 2'h0);
   assign rd_ok = (s_axi_araddr <= TWM_THR_OFS) && (s_axi_araddr[1:0] == 2'h0);
   assign wr_cmd    = (wr_go && s_axi_awaddr == TWM_CONTROL_OFS && s_axi_wstrb[0])
                      ? s_axi_wdata[7:0] : 8'h00;
   assign wr_swrst  = wr_cmd[TWM_CMD_SWRST];
   assign rd_status = rd_go && s_axi_araddr == TWM_STATUS_OFS;
   assign start_go  = wr_cmd[TWM_CMD_START] && master_en && !stuck; // R8
   assign low_t     = 15'(div.clock_low_divider) << div.divider_exponent;  // R1
   assign high_t    = 15'(div.clock_high_divider) << div.divider_exponent; // R1

   // read data mux
   always_comb
   begin
      rd_val = 32'h0;
      unique case (s_axi_araddr)
         TWM_MODE_OFS:     rd_val = 32'({mode.read_dir, 1'b0, mode.device_address_field});
         TWM_CLKDIV_OFS:   rd_val = 32'(div);
         TWM_STATUS_OFS:   rd_val = 32'({stuck, nack_flag, 5'h0, transmit_ready_flag, receive_ready_flag, transfer_complete_flag});
         TWM_IRQ_STAT_OFS: rd_val = 32'(irq_stat);
         TWM_IRQ_MASK_OFS: rd_val = 32'(irq_mask);
         TWM_RHR_OFS:      rd_val = 32'(rhr);
         default:          rd_val = 32'h0;
      endcase
   end

   // bus responses; unmapped or misaligned answers slave error
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= TWM_RESP_OKAY;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp  <= TWM_RESP_OKAY;
         s_axi_rdata  <= 32'h0;
      end
      else
      begin
         if (wr_go)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? TWM_RESP_OKAY : TWM_RESP_SLVERR;
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
         if (rd_go)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= rd_ok ? TWM_RESP_OKAY : TWM_RESP_SLVERR;
            s_axi_rdata  <= rd_val;
         end
         else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   // configuration registers
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         div      <= twm_div_type'(TWM_CLKDIV_RESET);
         mode     <= '0;
         irq_mask <= TWM_IRQ_RESET;
         thr      <= 8'h00;
      end
      else if (wr_go)
      begin
         unique case (s_axi_awaddr)
            TWM_MODE_OFS:     mode <= twm_mode_type'({s_axi_wdata[TWM_MODE_DIR],
                                                      s_axi_wdata[6:0]});
            TWM_CLKDIV_OFS:   div <= twm_div_type'(s_axi_wdata[18:0]);
            TWM_IRQ_MASK_OFS: irq_mask <= s_axi_wdata[2:0];
            TWM_THR_OFS:      thr <= s_axi_wdata[7:0];
            default:          ;
         endcase
      end
   end

   // enable, stuck and stop request control bits
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         master_en <= 1'b0;
         stuck     <= 1'b0;
         stop_req  <= 1'b0;
      end
      else
      begin
         if (wr_cmd[TWM_CMD_DISABLE] || wr_swrst)
            master_en <= 1'b0; // R2
         else if (wr_cmd[TWM_CMD_ENABLE])
            master_en <= 1'b1;
         // the lost clock edge leaves the engine unable to launch again
         if (wr_swrst && state != TWM_IDLE && !scl_s)
            stuck <= 1'b1; // R8
         if (wr_cmd[TWM_CMD_STOP])
            stop_req <= 1'b1;
         else if (wr_swrst || (state == TWM_STOP_LOW && master_en))
            stop_req <= 1'b0;
      end
   end

   // status flags; hardware sets win over software clears
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         transfer_complete_flag    <= 1'b1;
         transmit_ready_flag     <= 1'b1;
         receive_ready_flag     <= 1'b0;
         nack_flag <= 1'b0;
         nack_pend <= 1'b0;
         rhr       <= 8'h00;
      end
      else
      begin
         if (evt_done)
            transfer_complete_flag <= 1'b1;
         else if (start_go || wr_swrst)
            transfer_complete_flag <= 1'b0;
         if (evt_take)
            transmit_ready_flag <= 1'b1;
         else if (wr_go && s_axi_awaddr == TWM_THR_OFS)
            transmit_ready_flag <= 1'b0;
         if (evt_rxbyte)
            receive_ready_flag <= 1'b1;
         else if (rd_go && s_axi_araddr == TWM_RHR_OFS)
            receive_ready_flag <= 1'b0;
         // a status read before completion discards the pending detection
         if (evt_nack)
            nack_pend <= 1'b1;
         else if (rd_status || evt_done)
            nack_pend <= 1'b0; // R5
         if (evt_done && nack_pend)
            nack_flag <= 1'b1; // R4
         else if (rd_status)
            nack_flag <= 1'b0; // R4
         if (evt_byte)
            rhr <= shifter; // R6
      end
   end

   // sticky interrupt status, write one to clear
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         irq_stat <= TWM_IRQ_RESET;
      else
         irq_stat <= {evt_done && nack_pend, evt_rxbyte, evt_done}
                     | (irq_stat & ~((wr_go && s_axi_awaddr == TWM_IRQ_STAT_OFS)
                                     ? s_axi_wdata[2:0] : 3'h0));
   end
   assign irq = |(irq_stat & irq_mask);

   // serial engine; holds still while disabled, except that a soft reset still returns it to idle
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state      <= TWM_IDLE;
         cnt        <= 15'h0;
         shifter    <= 8'h00;
         bit_cnt    <= 4'h0;
         is_addr    <= 1'b0;
         rd_data    <= 1'b0;
         last_addr  <= 7'h00;
         scl_oe     <= 1'b0;
         sda_oe     <= 1'b0;
         evt_done   <= 1'b0;
         evt_byte   <= 1'b0;
         evt_rxbyte <= 1'b0;
         evt_take   <= 1'b0;
         evt_nack   <= 1'b0;
      end
      else
      begin
         evt_done   <= 1'b0;
         evt_byte   <= 1'b0;
         evt_rxbyte <= 1'b0;
         evt_take   <= 1'b0;
         evt_nack   <= 1'b0;
         if (wr_swrst)
         begin
            state  <= TWM_IDLE;
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
         end
         else if (master_en) // R2
         begin
            cnt <= cnt + 15'h1;
            unique case (state)
               TWM_IDLE:
                  if (start_go)
                  begin
                     state     <= TWM_START;
                     sda_oe    <= 1'b1; // R11
                     cnt       <= 15'h0;
                     last_addr <= mode.device_address_field;
                  end
               TWM_START:
                  if (cnt >= high_t)
                  begin
                     state   <= TWM_BIT_LOW;
                     scl_oe  <= 1'b1;
                     cnt     <= 15'h0;
                     shifter <= {mode.device_address_field, mode.read_dir};
                     bit_cnt <= 4'h0;
                     is_addr <= 1'b1;
                     rd_data <= 1'b0;
                  end
               TWM_BIT_LOW:
               begin
                  if (bit_cnt == 4'h8)
                     sda_oe <= rd_data && !stop_req; // acknowledge unless last
                  else
                     sda_oe <= !rd_data && !shifter[7];
                  if (cnt >= low_t)
                  begin
                     state  <= TWM_BIT_HIGH;
                     scl_oe <= 1'b0;
                     cnt    <= 15'h0;
                  end
               end
               TWM_BIT_HIGH:
                  if (!scl_s)
                     cnt <= 15'h0; // slave stretching the clock
                  else if (cnt >= high_t)
                  begin
                     scl_oe <= 1'b1;
                     cnt    <= 15'h0;
                     state  <= TWM_BIT_LOW;
                     if (bit_cnt != 4'h8)
                     begin
                        shifter <= {shifter[6:0], sda_s};
                        bit_cnt <= bit_cnt + 4'h1;
                     end
                     else
                     begin
                        bit_cnt    <= 4'h0;
                        is_addr    <= 1'b0;
                        evt_byte   <= !is_addr; // R6
                        evt_rxbyte <= rd_data;
                        if (!rd_data && sda_s)
                        begin
                           evt_nack <= 1'b1;
                           state    <= TWM_STOP_LOW;
                        end
                        else if (rd_data || (is_addr && mode.read_dir))
                        begin
                           rd_data <= 1'b1;
                           shifter <= 8'hff;
                           if (rd_data && stop_req)
                              state <= TWM_STOP_LOW;
                        end
                        else if (!transmit_ready_flag)
                        begin
                           shifter  <= thr;
                           evt_take <= 1'b1;
                        end
                        else if (stop_req)
                        begin
                           state    <= TWM_WAIT_STOP;
                           evt_done <= 1'b1;
                        end
                        else
                           state <= TWM_HOLD;
                     end
                  end
               TWM_HOLD:
                  if (!transmit_ready_flag)
                  begin
                     state    <= TWM_BIT_LOW;
                     shifter  <= thr;
                     evt_take <= 1'b1;
                     cnt      <= 15'h0;
                  end
                  else if (stop_req)
                  begin
                     state    <= TWM_WAIT_STOP;
                     evt_done <= 1'b1;
                     cnt      <= 15'h0;
                  end
               TWM_WAIT_STOP:
                  // restart to the same address resumes data without a stop
                  if (start_go && mode.device_address_field == last_addr)
                  begin
                     state   <= TWM_BIT_LOW; // R9
                     cnt     <= 15'h0;
                     rd_data <= mode.read_dir;
                     shifter <= mode.read_dir ? 8'hff : thr;
                     evt_take <= !mode.read_dir && !transmit_ready_flag;
                  end
                  else if (cnt >= low_t + high_t)
                  begin
                     state <= TWM_STOP_LOW;
                     cnt   <= 15'h0;
                  end
               TWM_STOP_LOW:
               begin
                  sda_oe <= 1'b1;
                  if (cnt >= low_t)
                  begin
                     state  <= TWM_STOP_HIGH;
                     scl_oe <= 1'b0;
                     cnt    <= 15'h0;
                  end
               end
               TWM_STOP_HIGH:
                  if (!scl_s)
                     cnt <= 15'h0;
                  else if (cnt >= high_t)
                  begin
                     state    <= TWM_IDLE;
                     sda_oe   <= 1'b0; // R11
                     evt_done <= 1'b1;
                  end
            endcase
         end
      end
   end

   // a last event pulse or a software write may still move the flags, so both are excluded
   AST_FREEZE: assert property (@(posedge mclk) disable iff (!rst_n) // R2
      !master_en && !$past(master_en) && !wr_go
      |=> $stable(state) && $stable(transfer_complete_flag) && $stable(transmit_ready_flag))
      else $error("disabled engine moved");
   AST_NACK_DONE: assert property (@(posedge mclk) disable iff (!rst_n) // R4
      $rose(nack_flag) |-> transfer_complete_flag && $rose(irq_stat[0]))
      else $error("nack rose without completion");
   AST_NACK_CLEAR: assert property (@(posedge mclk) disable iff (!rst_n) // R4
      rd_status && !(evt_done && nack_pend) |=> !nack_flag)
      else $error("status read left nack set");
   AST_RHR_LOAD: assert property (@(posedge mclk) disable iff (!rst_n) // R6
      evt_byte && !evt_rxbyte |=> rhr == $past(shifter) && $stable(receive_ready_flag))
      else $error("transmitted byte handling wrong");
   AST_STUCK: assert property (@(posedge mclk) disable iff (!rst_n) // R8
      stuck && state == TWM_IDLE |=> state == TWM_IDLE [*2])
      else $error("stuck controller started");
   AST_NO_STOP: assert property (@(posedge mclk) disable iff (!rst_n) // R9
      state == TWM_WAIT_STOP && master_en && start_go
      && mode.device_address_field == last_addr |=> state == TWM_BIT_LOW && scl_oe)
      else $error("stop was not skipped");
   AST_START_COND: assert property (@(posedge mclk) disable iff (!rst_n) // R11
      state == TWM_IDLE && start_go && !wr_swrst |=> sda_oe && !scl_oe)
      else $error("start condition not driven");
endmodule

// file: twm_pkg.sv
/*
  twm_pkg: constants and carrier types for the two-wire master controller.
  Assumes a 32-bit AXI4-Lite register bus and a 125 MHz system clock.
*/
package twm_pkg;
   // register byte offsets
   localparam logic [7:0] TWM_CONTROL_OFS  = 8'h00;
   localparam logic [7:0] TWM_MODE_OFS     = 8'h04;
   localparam logic [7:0] TWM_CLKDIV_OFS   = 8'h08;
   localparam logic [7:0] TWM_STATUS_OFS   = 8'h0c;
   localparam logic [7:0] TWM_IRQ_STAT_OFS = 8'h10;
   localparam logic [7:0] TWM_IRQ_MASK_OFS = 8'h14;
   localparam logic [7:0] TWM_RHR_OFS      = 8'h18;
   localparam logic [7:0] TWM_THR_OFS      = 8'h1c;
   // control register command bits
   localparam int TWM_CMD_START   = 0;
   localparam int TWM_CMD_STOP    = 1;
   localparam int TWM_CMD_ENABLE  = 2;
   localparam int TWM_CMD_DISABLE = 3;
   localparam int TWM_CMD_SWRST   = 7;
   // status bit positions; interrupt bits 0 and 1 match them, the nack interrupt is bit 2
   localparam int TWM_ST_TRANSFER_COMPLETE_FLAG = 0;
   localparam int TWM_ST_RECEIVE_READY_FLAG  = 1;
   localparam int TWM_ST_TRANSMIT_READY_FLAG  = 2;
   localparam int TWM_ST_NACK   = 8;
   localparam int TWM_ST_STUCK  = 9;
   // mode register: address in [6:0], read direction in bit 8
   localparam int TWM_MODE_DIR = 8;
   // values after reset
   localparam logic [18:0] TWM_CLKDIV_RESET = 19'h00000;
   localparam logic [2:0]  TWM_IRQ_RESET    = 3'h0;
   localparam logic [1:0]  TWM_RESP_OKAY    = 2'h0;
   localparam logic [1:0]  TWM_RESP_SLVERR  = 2'h2;
   localparam int          TWM_SYNC_STAGES  = 2;

   typedef struct packed {
      logic [2:0] divider_exponent;
      logic [7:0] clock_high_divider;
      logic [7:0] clock_low_divider;
   } twm_div_type;

   typedef struct packed {
      logic       read_dir;
      logic [6:0] device_address_field;
   } twm_mode_type;

   typedef enum logic [2:0] {
      TWM_IDLE      = 3'b000,
      TWM_START     = 3'b001,
      TWM_BIT_LOW   = 3'b010,
      TWM_BIT_HIGH  = 3'b011,
      TWM_HOLD      = 3'b100,
      TWM_WAIT_STOP = 3'b101,
      TWM_STOP_LOW  = 3'b110,
      TWM_STOP_HIGH = 3'b111
   } twm_state_type;
endpackage

// file: twm_sync.sv
/*
  twm_sync: two-stage synchroniser for pin levels.
  Assumes inputs may change at any time relative to clk.
*/
`timescale 1ns/1ps
module twm_sync
   import twm_pkg::*;
#(
   parameter int WIDTH = 2
)
(
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] din,
   output logic      [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] stage1;

   // first stage feeds only the second; lines idle high
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         stage1 <= '1;
         dout   <= '1;
      end
      else
      begin
         stage1 <= din;
         dout   <= stage1;
      end
   end
endmodule

// file: twm_slave_model.sv
/*
  twm_slave_model: behavioural two-wire slave that acknowledges and records bytes.
  Assumes open-drain lines with pull-ups, resolved by the bench from all pulls.
*/
`timescale 1ns/1ps
module twm_slave_model
(
   input  wire logic scl,
   input  wire logic sda,
   input  wire logic nack_addr,
   input  wire logic stretch,
   output logic      sda_pull,
   output logic      scl_pull
);
   logic [7:0] got[$];
   logic [7:0] sh;
   bit         first;

   initial
   begin
      sda_pull = 1'b0;
      scl_pull = 1'b0;
   end

   // a stop ends the frame; data is let go so the pull-up wins
   always @(posedge sda)
      if (scl === 1'b1)
      begin
         disable frame;
         sda_pull <= 1'b0;
      end

   // msb first, then the slave drives the acknowledge slot
   always
   begin : frame
      @(negedge sda iff scl === 1'b1);
      first = 1'b1;
      forever
      begin
         repeat (8) @(posedge scl) sh = {sh[6:0], sda};
         @(negedge scl);
         got.push_back(sh);
         sda_pull <= !(first && nack_addr);
         @(negedge scl);
         sda_pull <= 1'b0;
         first = 1'b0;
         // a slow slave stretches the low phase after each acknowledge
         if (stretch)
         begin
            scl_pull = 1'b1;
            #200 scl_pull = 1'b0;
         end
      end
   end
endmodule

// file: tb_top.sv
/*
  tb_top: self-checking bench for the two-wire master controller.
  Assumes one behavioural slave model on open-drain lines with pull-ups.
*/
`timescale 1ns/1ps
module tb_top
   import twm_pkg::*;
   ;
   localparam logic [31:0] ST_IDLE = (32'h1 << TWM_ST_TRANSFER_COMPLETE_FLAG) | (32'h1 << TWM_ST_TRANSMIT_READY_FLAG);
   logic        mclk, rstn, nack_addr, stretch, s_scl, s_sda;
   logic [7:0]  s_axi_awaddr, s_axi_araddr, b, b2;
   logic [6:0]  a;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0]  s_axi_wstrb;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rs, held;
   logic        scl_out, scl_oe, sda_out, sda_oe, irq;
   logic [7:0]  exp_q[$];
   int          n_mismatch, comparisons, cyc;
   wire logic   scl = (scl_oe ? scl_out : 1'b1) & !s_scl;
   wire logic   sda = (sda_oe ? sda_out : 1'b1) & !s_sda;

   twm_master u_twm_master (.mclk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .scl_in(scl), .scl_out, .scl_oe,
      .sda_in(sda), .sda_out, .sda_oe, .irq);
   twm_slave_model u_twm_slave_model (.scl, .sda, .nack_addr, .stretch, .sda_pull(s_sda),
      .scl_pull(s_scl));

   always #4 mclk = ~mclk;

   // hang guard: whole run needs under two thousand cycles
   always @(posedge mclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         n_mismatch++;
         close_out();
      end
   end

   task automatic close_out();
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chk_pin(input string nm, input logic e, input logic g);
      comparisons++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("[FAIL] %s expected %b seen %b", nm, e, g);
      end
   endtask

   // address and data offered together, held until taken; response lands in rs
   task automatic axi_wr(input logic [7:0] ad, input logic [31:0] d);
      @(posedge mclk);
      s_axi_awaddr  <= ad;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      @(posedge mclk);
      while (!(s_axi_awready && s_axi_wready)) @(posedge mclk);
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid  <= 1'b0;
      while (s_axi_bvalid !== 1'b1) @(posedge mclk);
      rs = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   task automatic axi_rd(input logic [7:0] ad);
      @(posedge mclk);
      s_axi_araddr  <= ad;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      @(posedge mclk);
      while (!s_axi_arready) @(posedge mclk);
      s_axi_arvalid <= 1'b0;
      while (s_axi_rvalid !== 1'b1) @(posedge mclk);
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   // one write frame; the reference queue holds what the slave must see
   task automatic xfer(input bit again);
      exp_q = {{a, 1'b0}};
      if (!nack_addr)
         exp_q.push_back(b);
      if (again)
         exp_q.push_back(b2);
      u_twm_slave_model.got.delete();
      axi_wr(TWM_MODE_OFS, {25'h0, a});
      axi_wr(TWM_CONTROL_OFS, 32'h1 << TWM_CMD_START);
      axi_wr(TWM_THR_OFS, {24'h0, b});
      axi_wr(TWM_CONTROL_OFS, 32'h1 << TWM_CMD_STOP);
      while (irq !== 1'b1) @(posedge mclk);
      // same address at once, inside the stop delay: the slave sees one frame, no stop
      if (again)
      begin
         axi_wr(TWM_THR_OFS, {24'h0, b2});
         axi_wr(TWM_CONTROL_OFS, 32'h1 << TWM_CMD_START);
         axi_wr(TWM_IRQ_STAT_OFS, 32'h7);
         while (irq !== 1'b1) @(posedge mclk);
      end
      repeat (60) @(posedge mclk);
      chk_reg("byte count", 32'(exp_q.size()), 32'(u_twm_slave_model.got.size()));
      foreach (exp_q[i]) chk_reg("bus byte", exp_q[i], u_twm_slave_model.got[i]);
   endtask

   initial
   begin
      {mclk, rstn, nack_addr, stretch, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hf;
      void'($urandom(59481));
      repeat (2) @(posedge mclk);
      rstn <= 1'b1;
      repeat (5) @(posedge mclk);
      axi_rd(TWM_STATUS_OFS);
      chk_reg("status", ST_IDLE, rd);
      axi_rd(TWM_IRQ_MASK_OFS);
      chk_reg("irq mask", 32'h0, rd);
      axi_rd(8'h20);
      chk_reg("rresp", 32'(TWM_RESP_SLVERR), 32'(rs));
      axi_wr(8'h24, 32'h1);
      chk_reg("bresp", 32'(TWM_RESP_SLVERR), 32'(rs));
      axi_wr(TWM_CLKDIV_OFS, 32'h0404);
      axi_wr(TWM_CONTROL_OFS, 32'h1 << TWM_CMD_ENABLE);
      axi_wr(TWM_IRQ_MASK_OFS, 32'h5);
      // acknowledged frame with a slow slave
      a = 7'($urandom);
      b = 8'($urandom);
      stretch = 1'b1;
      xfer(1'b0);
      axi_rd(TWM_RHR_OFS);
      chk_reg("holding", {24'h0, b}, rd);
      axi_rd(TWM_STATUS_OFS);
      chk_reg("status", 32'h1, rd & 32'h3);
      axi_wr(TWM_IRQ_MASK_OFS, 32'h0);
      chk_pin("irq masked", 1'b0, irq);
      axi_wr(TWM_IRQ_MASK_OFS, 32'h5);
      chk_pin("irq unmasked", 1'b1, irq);
      axi_wr(TWM_IRQ_STAT_OFS, 32'h7);
      chk_pin("irq cleared", 1'b0, irq);
      // back-to-back transfer to the same address right after completion
      b2 = 8'($urandom);
      xfer(1'b1);
      axi_rd(TWM_RHR_OFS);
      chk_reg("holding", {24'h0, b2}, rd);
      axi_wr(TWM_IRQ_STAT_OFS, 32'h7);
      // address refused by the slave
      stretch = 1'b0;
      nack_addr = 1'b1;
      xfer(1'b0);
      axi_rd(TWM_STATUS_OFS);
      chk_reg("nack status", 32'h101, rd & 32'h101);
      axi_rd(TWM_STATUS_OFS);
      chk_reg("nack cleared", 32'h0, rd & 32'h100);
      axi_wr(TWM_IRQ_STAT_OFS, 32'h7);
      // disable mid-frame with the clock held low, then soft reset
      axi_wr(TWM_IRQ_MASK_OFS, 32'h0);
      nack_addr = 1'b0;
      axi_wr(TWM_CONTROL_OFS, 32'h1 << TWM_CMD_START);
      while (scl_oe !== 1'b1) @(posedge mclk);
      axi_wr(TWM_CONTROL_OFS, 32'h1 << TWM_CMD_DISABLE);
      held = {scl_oe, sda_oe};
      repeat (40) @(posedge mclk);
      chk_reg("frozen pins", 32'(held), 32'({scl_oe, sda_oe}));
      axi_rd(TWM_STATUS_OFS);
      // start cleared completion; the byte refused by the nack frame still waits
      chk_reg("flags kept", 32'h0, rd & 32'h5);
      axi_wr(TWM_CONTROL_OFS, 32'h1 << TWM_CMD_SWRST);
      axi_rd(TWM_STATUS_OFS);
      chk_reg("stuck", 32'h1 << TWM_ST_STUCK, rd & (32'h1 << TWM_ST_STUCK));
      axi_wr(TWM_CONTROL_OFS, 32'h1 << TWM_CMD_ENABLE);
      axi_wr(TWM_CONTROL_OFS, 32'h1 << TWM_CMD_START);
      repeat (2) @(posedge mclk);
      chk_pin("no start", 1'b0, sda_oe);
      close_out();
   end
endmodule
